// >>> rtl/p2g_port.v
// Summary of operation
// - eight independently configured pins; data register reads pins and drives them
// - pin data register sits at index F2h
// - high mode byte covers pins 7..4, low mode byte pins 3..0
// - reset clears both mode bytes, every pin becomes input
// - two-bit field per pin, pin 7 at [7:6] down to pin 4 at [1:0]
// - 00 falling, 01 both edges, 11 rising; each an armed input
// - mode 10 makes an output, driver type from output type register
// - pins 7..4 share one source; pins 3..0 have own sources
// - per-pin pull-up enable register at index EEh
// - output type bit 0 push-pull, 1 open-drain
// - edge requests interrupt only while the pin's enable bit is 1
// - pending flag set on edge; write 0 clears, write 1 keeps
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "p2g_map.vh"

module p2g_port #(
  parameter NPIN = 8,
  parameter AW = 12
) (
  input wire core_clk_i,
  input wire rst_b_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [AW-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // pins
  input wire [NPIN-1:0] pin_in_i,
  output reg [NPIN-1:0] pin_out_o,
  output reg [NPIN-1:0] pin_oe_o,
  output reg [NPIN-1:0] pin_pullup_o,
  // interrupt sources
  output wire pin0_irq_o,
  output wire pin1_irq_o,
  output wire pin2_irq_o,
  output wire pin3_irq_o,
  output wire shared_upper_pin_irq_o,
  output wire irq_o
);

  // true when a mode field selects output
  function is_out;
    input [1:0] mode;
    begin
      is_out = (mode == `P2G_MODE_OUT);
    end
  endfunction

  // true when the address lands on a register index (upper bits must be zero)
  function hit;
    input [AW-1:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[`P2G_ADDR_IDX_MSB:`P2G_ADDR_IDX_LSB] == idx) &&
            (addr[1:0] == 2'b00) &&
            (addr[AW-1:`P2G_ADDR_IDX_MSB+1] == {(AW-`P2G_ADDR_IDX_MSB-1){1'b0}});
    end
  endfunction

  // software-visible register state
  reg [7:0] hi_mode_q;
  reg [7:0] lo_mode_q;
  reg [7:0] pullup_q;
  reg [7:0] data_q;
  reg [7:0] otype_q;
  reg [7:0] en_q;

  // next values of that state
  reg [7:0] hi_mode_d;
  reg [7:0] lo_mode_d;
  reg [7:0] pullup_d;
  reg [7:0] data_d;
  reg [7:0] otype_d;
  reg [7:0] en_d;

  // bus answer and read path
  reg [31:0] rdata_d;
  reg mapped_d;
  reg [31:0] prdata_d;
  reg pready_d;
  reg pslverr_d;

  // per-pin mode, level, events and pending flags
  wire [15:0] mode_all;
  wire [NPIN-1:0] out_mode;
  wire [NPIN-1:0] level;
  wire [NPIN-1:0] edge_ev;
  wire [7:0] pnd;

  // bus phase, address decode and write strobes
  wire setup;
  wire wr_go;
  wire sel_hi;
  wire sel_lo;
  wire sel_pu;
  wire sel_data;
  wire sel_otype;
  wire sel_en;
  wire sel_pnd;
  wire wr_hi;
  wire wr_lo;
  wire wr_pu;
  wire wr_data;
  wire wr_otype;
  wire wr_en;
  wire wr_pnd;

  // decode of the held address
  assign sel_hi = hit(paddr_i, `P2G_IDX_HI);
  assign sel_lo = hit(paddr_i, `P2G_IDX_LO);
  assign sel_pu = hit(paddr_i, `P2G_IDX_PU);
  assign sel_data = hit(paddr_i, `P2G_IDX_DATA);
  assign sel_otype = hit(paddr_i, `P2G_IDX_OTYPE);
  assign sel_en = hit(paddr_i, `P2G_IDX_EN);
  assign sel_pnd = hit(paddr_i, `P2G_IDX_PND);

  // setup phase and the access edge on which a write lands
  assign setup = psel_i & ~penable_i;
  assign wr_go = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

  // per-register write strobes, one access edge each
  assign wr_hi = wr_go & sel_hi;
  assign wr_lo = wr_go & sel_lo;
  assign wr_pu = wr_go & sel_pu;
  assign wr_data = wr_go & sel_data;
  assign wr_otype = wr_go & sel_otype;
  assign wr_en = wr_go & sel_en;
  assign wr_pnd = wr_go & sel_pnd;

  // pin i mode field sits at bits [2i+1:2i] of {high, low}
  assign mode_all = {hi_mode_q, lo_mode_q};

  // read mux; data register returns synchronised pin levels
  always @*
  begin
    rdata_d = 32'h0000_0000;
    mapped_d = 1'b1;
    if (sel_hi)
      rdata_d[7:0] = hi_mode_q;
    else if (sel_lo)
      rdata_d[7:0] = lo_mode_q;
    else if (sel_pu)
      rdata_d[7:0] = pullup_q;
    else if (sel_data)
      rdata_d[7:0] = level;
    else if (sel_otype)
      rdata_d[7:0] = otype_q;
    else if (sel_en)
      rdata_d[7:0] = en_q;
    else if (sel_pnd)
      rdata_d[7:0] = pnd;
    else
      mapped_d = 1'b0;
  end

  // apb answer: data and error captured in setup, ready for one access cycle
  always @*
  begin
    prdata_d = prdata_o;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup)
    begin
      prdata_d = pwrite_i ? 32'h0000_0000 : rdata_d;
      pready_d = 1'b1; // zero wait states
      pslverr_d = ~mapped_d; // unmapped index or misaligned address
    end
  end

  // answer registers; read data holds until the next setup
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      prdata_o <= prdata_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
    end
  end

  // next values of the software-written registers
  always @*
  begin
    hi_mode_d = hi_mode_q;
    lo_mode_d = lo_mode_q;
    pullup_d = pullup_q;
    data_d = data_q;
    otype_d = otype_q;
    en_d = en_q;
    if (wr_hi)
      hi_mode_d = pwdata_i[7:0];
    if (wr_lo)
      lo_mode_d = pwdata_i[7:0];
    if (wr_pu)
      pullup_d = pwdata_i[7:0];
    if (wr_data)
      data_d = pwdata_i[7:0];
    if (wr_otype)
      otype_d = pwdata_i[7:0];
    if (wr_en)
      en_d = pwdata_i[7:0];
  end

  // software-written registers
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hi_mode_q <= `P2G_RST_HI;
      lo_mode_q <= `P2G_RST_LO;
      pullup_q <= `P2G_RST_PU;
      data_q <= `P2G_RST_DATA;
      otype_q <= `P2G_RST_OTYPE;
      en_q <= `P2G_RST_EN;
    end
    else
    begin
      hi_mode_q <= hi_mode_d;
      lo_mode_q <= lo_mode_d;
      pullup_q <= pullup_d;
      data_q <= data_d;
      otype_q <= otype_d;
      en_q <= en_d;
    end
  end

  // per-pin synchroniser, edge detector and driver
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_pin
      wire [1:0] mode;
      wire out_d;
      wire oe_d;
      wire pu_d;

      // this pin's two-bit field and its output-mode decode
      assign mode = mode_all[2*gi+1:2*gi];
      assign out_mode[gi] = is_out(mode);

      p2g_edge_det u_edge (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(pin_in_i[gi]),
        .mode_i(mode),
        .level_o(level[gi]),
        .edge_o(edge_ev[gi])
      );

      // driver next values: push-pull drives both levels, open-drain only low
      assign out_d = data_q[gi];
      assign oe_d = out_mode[gi] & ((otype_q[gi] == `P2G_OTYPE_PP) | ~data_q[gi]);
      assign pu_d = pullup_q[gi] & ~out_mode[gi]; // pull-up off while driving

      // driver registers, so every pin output leaves a flip-flop
      always @(posedge core_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pin_out_o[gi] <= 1'b0;
          pin_oe_o[gi] <= 1'b0;
          pin_pullup_o[gi] <= 1'b0;
        end
        else
        begin
          pin_out_o[gi] <= out_d;
          pin_oe_o[gi] <= oe_d;
          pin_pullup_o[gi] <= pu_d;
        end
      end
    end
  endgenerate

  // pending flags and source routing
  p2g_irq_ctl #(
    .WIDTH(NPIN)
  ) u_irq (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .edge_i(edge_ev),
    .en_i(en_q),
    .pnd_wr_i(wr_pnd),
    .pnd_wdata_i(pwdata_i[NPIN-1:0]),
    .pnd_q(pnd),
    .pin0_irq_q(pin0_irq_o),
    .pin1_irq_q(pin1_irq_o),
    .pin2_irq_q(pin2_irq_o),
    .pin3_irq_q(pin3_irq_o),
    .shared_upper_pin_irq_q(shared_upper_pin_irq_o),
    .irq_q(irq_o)
  );

endmodule // p2g_port

`default_nettype wire

// >>> common/p2g_map.vh
`ifndef P2G_MAP_VH
`define P2G_MAP_VH

// register indices; the bus byte address is four times the index
`define P2G_IDX_EN 8'hE5
`define P2G_IDX_PND 8'hE6
`define P2G_IDX_HI 8'hEC
`define P2G_IDX_LO 8'hED
`define P2G_IDX_PU 8'hEE
`define P2G_IDX_DATA 8'hF2
`define P2G_IDX_OTYPE 8'hF3

// index field inside the bus address
`define P2G_ADDR_IDX_MSB 9
`define P2G_ADDR_IDX_LSB 2

// mode field layout and codes
`define P2G_MODE_W 2
`define P2G_MODE_FALL 2'b00
`define P2G_MODE_BOTH 2'b01
`define P2G_MODE_OUT 2'b10
`define P2G_MODE_RISE 2'b11

// output type codes
`define P2G_OTYPE_PP 1'b0
`define P2G_OTYPE_OD 1'b1

// reset values
`define P2G_RST_HI 8'h00
`define P2G_RST_LO 8'h00
`define P2G_RST_PU 8'h00
`define P2G_RST_DATA 8'h00
`define P2G_RST_OTYPE 8'h00
`define P2G_RST_EN 8'h00
`define P2G_RST_PND 8'h00

// interrupt source grouping: pins at and above this share one source
`define P2G_SHARED_FIRST_PIN 4

`endif

// >>> rtl/p2g_edge_det.v
`timescale 1ns/100ps
`default_nettype none
`include "p2g_map.vh"

module p2g_edge_det (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire pin_i,
  input wire [1:0] mode_i,
  output wire level_o,
  output wire edge_o
);

  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  wire rise;
  wire fall;

  // two-flop synchroniser, then a history flop for edge detection
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign level_o = sync2_q;
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // edge selection by mode; output mode detects nothing
  assign edge_o = ((mode_i == `P2G_MODE_FALL) & fall) |
                  ((mode_i == `P2G_MODE_BOTH) & (rise | fall)) |
                  ((mode_i == `P2G_MODE_RISE) & rise);

endmodule // p2g_edge_det

`default_nettype wire

// >>> rtl/p2g_irq_ctl.v
`timescale 1ns/100ps
`default_nettype none
`include "p2g_map.vh"

module p2g_irq_ctl #(
  parameter WIDTH = 8
) (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] edge_i,
  input wire [WIDTH-1:0] en_i,
  input wire pnd_wr_i,
  input wire [WIDTH-1:0] pnd_wdata_i,
  output reg [WIDTH-1:0] pnd_q,
  output reg pin0_irq_q,
  output reg pin1_irq_q,
  output reg pin2_irq_q,
  output reg pin3_irq_q,
  output reg shared_upper_pin_irq_q,
  output reg irq_q
);

  reg [WIDTH-1:0] pnd_d;
  wire [WIDTH-1:0] req;

  // write 0 clears, write 1 keeps; a new edge wins over the clear
  always @*
  begin
    pnd_d = pnd_q;
    if (pnd_wr_i)
      pnd_d = pnd_q & pnd_wdata_i;
    pnd_d = pnd_d | edge_i;
  end

  // a pending flag requests only while its enable is set
  assign req = pnd_q & en_i;

  // source mapping, registered
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pnd_q <= `P2G_RST_PND;
      pin0_irq_q <= 1'b0;
      pin1_irq_q <= 1'b0;
      pin2_irq_q <= 1'b0;
      pin3_irq_q <= 1'b0;
      shared_upper_pin_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      pnd_q <= pnd_d;
      pin0_irq_q <= req[0];
      pin1_irq_q <= req[1];
      pin2_irq_q <= req[2];
      pin3_irq_q <= req[3];
      shared_upper_pin_irq_q <= |req[WIDTH-1:`P2G_SHARED_FIRST_PIN];
      irq_q <= |req;
    end
  end

endmodule // p2g_irq_ctl

`default_nettype wire

// >>> dv/p2g_port_chk.sv
`timescale 1ns/100ps
`default_nettype none
module p2g_port_chk (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pin_pullup_o,
  input wire logic pin0_irq_o,
  input wire logic pin1_irq_o,
  input wire logic pin2_irq_o,
  input wire logic pin3_irq_o,
  input wire logic shared_upper_pin_irq_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // bus phases
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && pready_o;
  endsequence
  // zero wait state answer, one cycle wide
  a_ready_pulse: assert property (s_setup |=> pready_o)
    else $error("ready missing after setup");
  a_ready_once: assert property (s_access |=> !pready_o)
    else $error("ready wider than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  // requests and pins
  a_irq_combine: assert property (irq_o == (pin0_irq_o | pin1_irq_o
    | pin2_irq_o | pin3_irq_o | shared_upper_pin_irq_o))
    else $error("combined request mismatch");
  a_oe_pullup: assert property ((pin_oe_o & pin_pullup_o) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !irq_o && pin_oe_o == 8'h00)
    else $error("outputs active after reset");
  a_irq_fall: assert property ($fell(irq_o)
    |-> $past(psel_i && penable_i && pwrite_i && pready_o, 2))
    else $error("request dropped without a write");
endmodule // p2g_port_chk
bind p2g_port p2g_port_chk p2g_port_chk_inst (.core_clk_i, .rst_b_i, .psel_i, .penable_i,
  .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .pin_oe_o, .pin_pullup_o, .pin0_irq_o,
  .pin1_irq_o, .pin2_irq_o, .pin3_irq_o, .shared_upper_pin_irq_o, .irq_o);
`default_nettype wire

// >>> dv/p2g_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module p2g_pin_model (
  input wire logic core_clk_i,
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pin_pu_i,
  input wire logic [7:0] ext_oe_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_o
);
  logic [7:0] flt_q = 8'h00;
  // an unheld pin wanders every cycle
  always @(posedge core_clk_i) flt_q <= ~flt_q;
  // device drive wins, then outside circuit, then pull-up
  assign pin_o = pin_oe_i & pin_out_i | ~pin_oe_i & (ext_oe_i & ext_val_i
    | ~ext_oe_i & (pin_pu_i | flt_q));
endmodule // p2g_pin_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "p2g_map.vh"
module tb_top;
  logic clk, rst_b, psel, pen, pwr, pready, perr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pu, ext_oe, ext_val;
  logic [4:0] irqs;
  int num_errors, n_compared;
  p2g_port p2g_port_inst (.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .pin_pullup_o(pin_pu), .pin0_irq_o(irqs[0]), .pin1_irq_o(irqs[1]), .pin2_irq_o(irqs[2]),
    .pin3_irq_o(irqs[3]), .shared_upper_pin_irq_o(irqs[4]), .irq_o(irq));
  p2g_pin_model p2g_pin_model_inst (.core_clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .pin_pu_i(pin_pu), .ext_oe_i(ext_oe), .ext_val_i(ext_val), .pin_o(pin_in));
  // 10 MHz clock
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] ix, wd, input logic xe);
    int n;
    n = 0;
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    chk("pslverr", xe, perr);
    rdv = prdata;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ix, d);
    apb(1, ix, d, 0);
  endtask
  task automatic rd(input logic [7:0] ix, ex);
    apb(0, ix, 8'h00, 0);
    chk("rdata", {24'h0, ex}, rdv);
  endtask
  // pins expected to pend for a mode map on a rise or a fall
  function automatic logic [7:0] ep(input logic [15:0] m, input logic r);
    for (int i = 0; i < 8; i++)
      ep[i] = r ? m[2*i] : !m[2*i+1];
  endfunction
  task automatic t_reset;
    logic [7:0] ix [7] = '{`P2G_IDX_EN, `P2G_IDX_PND, `P2G_IDX_HI, `P2G_IDX_LO,
      `P2G_IDX_PU, `P2G_IDX_DATA, `P2G_IDX_OTYPE};
    foreach (ix[i]) rd(ix[i], 8'h00);
    apb(0, 8'hE7, 8'h00, 1);
    chk("rdata", 0, rdv);
    apb(1, 8'hE7, 8'hFF, 1);
  endtask
  task automatic t_rw;
    logic [7:0] ix [5] = '{`P2G_IDX_EN, `P2G_IDX_HI, `P2G_IDX_LO, `P2G_IDX_PU, `P2G_IDX_OTYPE};
    foreach (ix[i]) wr(ix[i], 8'hD7);
    foreach (ix[i]) rd(ix[i], 8'hD7);
    chk("pullup", 8'hD7, pin_pu);
  endtask
  task automatic t_edges(input logic [15:0] m);
    logic [7:0] e;
    wr(`P2G_IDX_HI, m[15:8]);
    wr(`P2G_IDX_LO, m[7:0]);
    wr(`P2G_IDX_EN, m[15:8]);
    wr(`P2G_IDX_PND, 8'h00);
    for (int r = 1; r >= 0; r--)
    begin
      ext_val <= r ? 8'hFF : 8'h00;
      repeat (6) @(posedge clk);
      rd(`P2G_IDX_DATA, r ? 8'hFF : 8'h00);
      e = ep(m, r[0]);
      rd(`P2G_IDX_PND, e);
      e = e & m[15:8];
      chk("irqs", {|e, |e[7:4], e[3:0]}, {irq, irqs});
      wr(`P2G_IDX_PND, 8'hF0);
      rd(`P2G_IDX_PND, ep(m, r[0]) & 8'hF0);
      wr(`P2G_IDX_PND, 8'h00);
    end
  endtask
  task automatic t_out;
    wr(`P2G_IDX_PU, 8'hFF);
    ext_oe <= 8'hF0;
    wr(`P2G_IDX_OTYPE, 8'h0C);
    wr(`P2G_IDX_DATA, 8'h05);
    wr(`P2G_IDX_LO, 8'hAA);
    wr(`P2G_IDX_PND, 8'h00);
    repeat (2) @(posedge clk);
    chk("out", 8'h05, pin_out);
    chk("oe", 8'h0B, pin_oe);
    chk("pullup", 8'hF0, pin_pu);
    repeat (6) @(posedge clk);
    rd(`P2G_IDX_PND, 8'h00);
    ext_oe <= 8'hFF;
    wr(`P2G_IDX_LO, 8'h00);
  endtask
  task automatic summarize;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst_b = 0;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    ext_oe = 8'hFF;
    ext_val = 8'h00;
    num_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    t_reset();
    t_rw();
    t_edges(16'hD31C);
    t_edges(16'h1CD3);
    t_out();
    summarize();
  end
  // hang guard, about 20000 cycles
  initial
  begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
